//--- subtract_carry_alu_defines.svh
// Constants for the carrying subtract datapath: opcodes, fields, resets,
// flag layouts and register offsets. Included by the design, checker and bench.
`ifndef SUBTRACT_CARRY_ALU_DEFINES_SVH
`define SUBTRACT_CARRY_ALU_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction encoding (bit 0 is the most significant bit)
// ----------------------------------------------------------------------
`define OPC_PRIMARY_EXT      6'h1F
`define OPC_PRIMARY_IMM      6'h08
`define XOP_SUB_CARRY        9'h008
`define XOP_SUB_EXTENDED     9'h088

// ----------------------------------------------------------------------
// Register map, word addresses (byte address is four times this)
// ----------------------------------------------------------------------
`define REG_INSN             4'h0
`define REG_SRC_A            4'h1
`define REG_SRC_B            4'h2
`define REG_RESULT           4'h3
`define REG_XER              4'h4
`define REG_CR0              4'h5
`define REG_IRQ_STAT         4'h6
`define REG_IRQ_MASK         4'h7

// ----------------------------------------------------------------------
// Flag positions
// ----------------------------------------------------------------------
`define XER_CA_BIT           0
`define XER_OV_BIT           1
`define XER_SO_BIT           2
`define CR0_SO_BIT           0
`define CR0_EQ_BIT           1
`define CR0_GT_BIT           2
`define CR0_LT_BIT           3
`define IRQ_DONE_BIT         0
`define IRQ_OVF_BIT          1
`define IRQ_ILLEGAL_BIT      2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XER_RESET            3'h0
`define CR0_RESET            4'h0
`define WORD_RESET           32'h0000_0000

`endif

//--- subtract_carry_alu_pkg.sv
// Types shared by the subtract datapath and its adder.
// Assumes the defines header sits in the include path.
package subtract_carry_alu_pkg;

	typedef enum logic [1:0]
	{
		OP_NONE    = 2'h0,
		OP_CARRY   = 2'h1,
		OP_EXTEND  = 2'h3,
		OP_IMMED   = 2'h2
	} sub_op_t;

	typedef struct packed
	{
		logic [4:0] target_reg_field;
		logic [4:0] first_source_reg_field;
		logic [4:0] second_source_reg_field;
		logic       oe_bit;
		logic       record_bit;
		logic [15:0] imm;
	} insn_fields_t;

	typedef struct packed
	{
		logic [31:0] sum;
		logic        carry_out;
		logic        overflow;
	} add_res_t;

endpackage : subtract_carry_alu_pkg

//--- sub_adder.sv
// Three-operand adder: ~a + b + cin, with carry out and signed overflow.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
module sub_adder
	import subtract_carry_alu_pkg::*;
(
	// Operands
	input  wire logic [31:0] minuend_i,
	input  wire logic [31:0] subtrahend_i,
	input  wire logic        carry_i,
	// Result
	output add_res_t         res_o
);
	wire logic [31:0] inv_a;
	wire logic [32:0] wide;

	assign inv_a = ~subtrahend_i;
	assign wide  = {1'b0, inv_a} + {1'b0, minuend_i} + {32'h0000_0000, carry_i};
	assign res_o.sum       = wide[31:0];
	assign res_o.carry_out = wide[32];
	// Same-sign inputs giving a differently signed sum
	assign res_o.overflow  = (inv_a[31] == minuend_i[31]) &&
		(wide[31] != minuend_i[31]);

endmodule : sub_adder

//--- subtract_carry_alu.sv
// Carrying, extended and immediate subtract datapath with its own
// exception and condition flags, reached over classic Wishbone.
// Assumes single clock, synchronous reset, 32-bit word-aligned bus.
//
// Contract
// - carrying subtract writes ~a + b + 1
// - all subtract forms update carry flag
// - overflow-enable set updates overflow, summary overflow
// - record set writes condition field zero
// - four variants from overflow and record bits
// - legacy alias behaves exactly like new op
// - extended subtract writes ~a + b + carry
// - extended decode: opcode 31, extended 136
// - immediate subtract: signed immediate minus a
// - carrying decode: opcode 31, extended 8
// - immediate opcode 08, carry only, no cr
`timescale 1ns/1ps
`include "subtract_carry_alu_defines.svh"
module subtract_carry_alu
	import subtract_carry_alu_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [5:2]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	// Interrupt
	output logic             irq_o
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [31:0] insn_r;
	logic [31:0] src_a_r;
	logic [31:0] src_b_r;
	logic [31:0] result_r;
	logic [2:0]  xer_r;
	logic [3:0]  cr0_r;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_mask_r;
	logic        exec_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        err_r;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire logic        req;
	wire logic        wr_acc;
	wire logic        rd_acc;
	wire logic        mapped;
	wire logic [31:0] wmask;
	wire logic [31:0] wr_data;
	wire logic        wr_insn;
	wire logic        rd_stat;

	// Answer cycle blocks a retake of the still-held request
	assign req     = cyc_i && stb_i && !ack_r && !err_r;
	assign mapped  = (adr_i <= `REG_IRQ_MASK);
	assign wr_acc  = req && we_i && mapped;
	assign rd_acc  = req && !we_i && mapped;
	assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}},
		{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wr_insn = wr_acc && (adr_i == `REG_INSN);
	assign rd_stat = rd_acc && (adr_i == `REG_IRQ_STAT);

	function automatic logic [31:0] merge(input logic [31:0] old_v);
		merge = (old_v & ~wmask) | (dat_i & wmask);
	endfunction : merge

	assign wr_data = merge(insn_r);

	// ------------------------------------------------------------------
	// Software writes; unselected bytes keep their old value
	// ------------------------------------------------------------------
	wire logic [31:0] src_a_wr;
	wire logic [31:0] src_b_wr;
	wire logic [31:0] xer_wr;
	wire logic [31:0] cr0_wr;
	wire logic [31:0] mask_wr;
	wire logic        wr_src_a;
	wire logic        wr_src_b;
	wire logic        wr_xer;
	wire logic        wr_cr0;
	wire logic        wr_mask;

	assign src_a_wr = merge(src_a_r);
	assign src_b_wr = merge(src_b_r);
	assign xer_wr   = merge({29'h0000_0000, xer_r});
	assign cr0_wr   = merge({28'h000_0000, cr0_r});
	assign mask_wr  = merge({29'h0000_0000, irq_mask_r});
	assign wr_src_a = wr_acc && (adr_i == `REG_SRC_A);
	assign wr_src_b = wr_acc && (adr_i == `REG_SRC_B);
	assign wr_xer   = wr_acc && (adr_i == `REG_XER);
	assign wr_cr0   = wr_acc && (adr_i == `REG_CR0);
	assign wr_mask  = wr_acc && (adr_i == `REG_IRQ_MASK);

	// ------------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------------
	// Big-endian bit numbering: field bit k is vector bit 31-k
	wire logic [5:0]  primary;
	wire logic [8:0]  xop;
	wire insn_fields_t fld;
	wire sub_op_t     op;

	assign primary                     = insn_r[31:26];
	assign fld.target_reg_field        = insn_r[25:21];
	assign fld.first_source_reg_field  = insn_r[20:16];
	assign fld.second_source_reg_field = insn_r[15:11];
	assign fld.oe_bit                  = insn_r[10];
	assign xop                         = insn_r[9:1];
	assign fld.record_bit              = insn_r[0];
	assign fld.imm                     = insn_r[15:0];

	// One encoding serves both new and legacy mnemonics
	assign op =
		(primary == `OPC_PRIMARY_EXT && xop == `XOP_SUB_CARRY)
			? OP_CARRY :
		(primary == `OPC_PRIMARY_EXT && xop == `XOP_SUB_EXTENDED)
			? OP_EXTEND :
		(primary == `OPC_PRIMARY_IMM)
			? OP_IMMED :
			OP_NONE;

	// ------------------------------------------------------------------
	// Operand selection and adder
	// ------------------------------------------------------------------
	wire logic [31:0] minuend;
	wire logic        carry_in;
	add_res_t         add_res;

	assign minuend  = (op == OP_IMMED)
		? {{16{fld.imm[15]}}, fld.imm} : src_b_r;
	assign carry_in = (op == OP_EXTEND)
		? xer_r[`XER_CA_BIT] : 1'b1;

	sub_adder u_adder
	(
		.minuend_i    (minuend),
		.subtrahend_i (src_a_r),
		.carry_i      (carry_in),
		.res_o        (add_res)
	);

	// ------------------------------------------------------------------
	// Flag next values
	// ------------------------------------------------------------------
	wire logic        legal;
	wire logic        use_oe;
	wire logic        use_rc;
	wire logic        so_nxt;
	wire logic [2:0]  xer_nxt;
	wire logic [3:0]  cr0_nxt;
	wire logic        sum_neg;
	wire logic        sum_zero;

	assign legal   = (op != OP_NONE);
	// Immediate form has no option bits
	assign use_oe  = (op != OP_IMMED) && fld.oe_bit;
	assign use_rc  = (op != OP_IMMED) && fld.record_bit;
	assign so_nxt  = use_oe
		? (xer_r[`XER_SO_BIT] | add_res.overflow)
		: xer_r[`XER_SO_BIT];
	assign xer_nxt[`XER_CA_BIT] = add_res.carry_out;
	assign xer_nxt[`XER_OV_BIT] = use_oe
		? add_res.overflow : xer_r[`XER_OV_BIT];
	assign xer_nxt[`XER_SO_BIT] = so_nxt;
	assign sum_neg  = add_res.sum[31];
	assign sum_zero = (add_res.sum == 32'h0000_0000);
	assign cr0_nxt[`CR0_LT_BIT] = sum_neg;
	assign cr0_nxt[`CR0_GT_BIT] = !sum_neg && !sum_zero;
	assign cr0_nxt[`CR0_EQ_BIT] = sum_zero;
	assign cr0_nxt[`CR0_SO_BIT] = so_nxt;

	// ------------------------------------------------------------------
	// Events
	// ------------------------------------------------------------------
	wire logic [2:0] evt;

	assign evt[`IRQ_DONE_BIT]    = exec_r && legal;
	assign evt[`IRQ_OVF_BIT]     = exec_r && use_oe && add_res.overflow;
	assign evt[`IRQ_ILLEGAL_BIT] = exec_r && !legal;

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	logic [31:0] rd_data;

	always_comb
	begin
		unique case (adr_i)
			`REG_INSN:     rd_data = insn_r;
			`REG_SRC_A:    rd_data = src_a_r;
			`REG_SRC_B:    rd_data = src_b_r;
			`REG_RESULT:   rd_data = result_r;
			`REG_XER:      rd_data = {29'h0000_0000, xer_r};
			`REG_CR0:      rd_data = {28'h000_0000, cr0_r};
			`REG_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat_r};
			`REG_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask_r};
			default:       rd_data = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			dat_r <= `WORD_RESET;
		end
		else
		begin
			ack_r <= req && mapped;
			err_r <= req && !mapped;
			dat_r <= rd_acc ? rd_data : dat_r;
		end
	end

	assign ack_o = ack_r;
	assign err_o = err_r;
	assign dat_o = dat_r;

	// ------------------------------------------------------------------
	// Operand registers; a write to the instruction word executes it
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			insn_r  <= `WORD_RESET;
			src_a_r <= `WORD_RESET;
			src_b_r <= `WORD_RESET;
			exec_r  <= 1'b0;
		end
		else
		begin
			exec_r <= wr_insn;
			if (wr_insn)
				insn_r <= wr_data;
			if (wr_src_a)
				src_a_r <= src_a_wr;
			if (wr_src_b)
				src_b_r <= src_b_wr;
		end
	end

	// ------------------------------------------------------------------
	// Result and flags; execution wins over a software write
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			result_r <= `WORD_RESET;
			xer_r    <= `XER_RESET;
			cr0_r    <= `CR0_RESET;
		end
		else if (exec_r && legal)
		begin
			result_r <= add_res.sum;
			xer_r    <= xer_nxt;
			if (use_rc)
				cr0_r <= cr0_nxt;
		end
		else
		begin
			if (wr_xer)
				xer_r <= xer_wr[2:0];
			if (wr_cr0)
				cr0_r <= cr0_wr[3:0];
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status: read clears, a same-cycle event survives
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end
		else
		begin
			irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | evt;
			if (wr_mask)
				irq_mask_r <= mask_wr[2:0];
		end
	end

	assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule : subtract_carry_alu

//--- subtract_carry_alu_assertions.sv
// Checker for bus timing and carrying subtract results at the ports.
// Assumes sources are written before the instruction that uses them.
`timescale 1ns/1ps
`include "subtract_carry_alu_defines.svh"
module subtract_carry_alu_assertions
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Wishbone
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [5:2]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic        irq_o
);
	// ------------------------------------------------------------------
	// Operand shadow
	// ------------------------------------------------------------------
	logic [31:0] a_r, b_r, insn_r;
	wire         req    = cyc_i && stb_i;
	wire         fresh  = req && !ack_o && !err_o;
	wire         wr_ack = req && we_i && ack_o;
	wire         rd_ack = req && !we_i && ack_o;
	wire         is_cy  = insn_r[31:26] == `OPC_PRIMARY_EXT
		&& insn_r[9:1] == `XOP_SUB_CARRY;
	wire         is_imm = insn_r[31:26] == `OPC_PRIMARY_IMM;
	wire [31:0]  bop    = is_imm ? {{16{insn_r[15]}}, insn_r[15:0]} : b_r;
	wire [32:0]  exp_s  = {1'b0, ~a_r} + {1'b0, bop} + 33'h1;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			insn_r <= 32'h0;
		else if (wr_ack && adr_i == `REG_INSN)
			insn_r <= dat_i;
		if (wr_ack && adr_i == `REG_SRC_A)
			a_r <= dat_i;
		if (wr_ack && adr_i == `REG_SRC_B)
			b_r <= dat_i;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_next: assert property (fresh |=> ack_o ^ err_o)
		else $error("no answer one cycle after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_err_pulse: assert property (err_o |=> !err_o)
		else $error("err longer than one cycle");
	a_err_unmapped: assert property (fresh && adr_i > 4'h7 |=> err_o && !ack_o)
		else $error("unmapped address not refused");
	a_ack_mapped: assert property (fresh && adr_i <= 4'h7 |=> ack_o && !err_o)
		else $error("mapped address not acked");
	a_ack_cause: assert property ((ack_o || err_o) |-> $past(req))
		else $error("answer without request");
	// Reset edge itself moves the read data from unknown to zero
	a_dat_hold: assert property (
		$changed(dat_o) && !$past(rst_i) |-> rd_ack)
		else $error("read data moved outside a read");
	a_sub_result: assert property (
		rd_ack && adr_i == `REG_RESULT && (is_cy || is_imm)
		|-> dat_o == exp_s[31:0])
		else $error("subtract result wrong");
	a_carry_flag: assert property (
		rd_ack && adr_i == `REG_XER && (is_cy || is_imm)
		|-> dat_o[`XER_CA_BIT] == exp_s[32])
		else $error("carry flag wrong");

	c_result: cover property (rd_ack && adr_i == `REG_RESULT && is_cy);
	c_err: cover property (err_o);
	c_irq: cover property ($rose(irq_o));
endmodule : subtract_carry_alu_assertions

bind subtract_carry_alu subtract_carry_alu_assertions chk
(
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq_o(irq_o)
);

//--- issue_model.sv
// Issue-side model: drives the block as a classic Wishbone master.
// Assumes every request is answered by ack or err; no own timeout.
`timescale 1ns/1ps
module issue_model
(
	// Clock
	input  wire logic        clk_i,
	// Answer
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i,
	input  wire logic        err_i,
	// Request
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [5:2]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	initial
	begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end

	// ------------------------------------------------------------------
	// Single cycle; idle edge first keeps cyc low a cycle between calls
	// ------------------------------------------------------------------
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e,
		input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		do
			@(posedge clk_i);
		while (!(ack_i || err_i));
		q = dat_i;
		e = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask : xfer
endmodule : issue_model

//--- subtract_carry_alu_test.sv
// Bench for the subtract datapath: operations run as bus sequences.
// Assumes the issue model as sole master; expectations kept locally.
`timescale 1ns/1ps
`include "subtract_carry_alu_defines.svh"
module subtract_carry_alu_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i, stb_i, we_i, ack_o, err_o, irq_o, e;
	logic [5:2]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	int          failures = 0;
	int          check_count = 0;
	logic [2:0]  xer = 3'h0;
	logic [3:0]  cr0 = 4'h0;
	logic [2:0]  stat = 3'h0;
	logic [31:0] last_res = 32'h0;
	logic [31:0] va [5] = '{32'h80007000, 32'h00004500, 32'h80000000,
		32'h80000000, 32'h12345678};
	logic [31:0] vb [5] = '{32'h90003000, 32'h80007000, 32'h00004500,
		32'hEFFFFFFF, 32'h12345678};

	always #2 clk_i = ~clk_i;

	subtract_carry_alu uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.irq_o(irq_o));
	issue_model master (.clk_i(clk_i), .dat_i(dat_o), .ack_i(ack_o),
		.err_i(err_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// ------------------------------------------------------------------
	// One operation: 0 carrying, 1 extended, 2 immediate, 3 illegal
	// ------------------------------------------------------------------
	task automatic run(input int k, input logic [31:0] a, input logic [31:0] b,
		input logic oe, input logic rc);
		logic [31:0] insn, bo;
		logic [32:0] s;
		logic        vf;
		bo = (k == 2) ? {{16{b[15]}}, b[15:0]} : b;
		s = {1'b0, ~a} + {1'b0, bo} + {32'h0, (k == 1) ? xer[0] : 1'b1};
		vf = (~a[31] == bo[31]) && (s[31] != bo[31]);
		insn = {`OPC_PRIMARY_EXT, 15'h0, oe, (k == 1) ? `XOP_SUB_EXTENDED
			: (k == 0) ? `XOP_SUB_CARRY : 9'h028, rc};
		if (k == 2)
			insn = {`OPC_PRIMARY_IMM, 10'h0, b[15:0]};
		master.xfer(1'b1, `REG_SRC_A, a, q, e);
		master.xfer(1'b1, `REG_SRC_B, b, q, e);
		master.xfer(1'b1, `REG_INSN, insn, q, e);
		stat = stat | {k == 3, oe && k < 2 && vf, k < 3};
		if (k < 3)
		begin
			last_res = s[31:0];
			xer[0] = s[32];
			if (oe && k < 2)
				xer[2:1] = {xer[2] | vf, vf};
			if (rc && k < 2)
				cr0 = {s[31], !s[31] && s[31:0] != 0, s[31:0] == 0, xer[2]};
		end
		master.xfer(1'b0, `REG_RESULT, 32'h0, q, e);
		check(q, last_res);
		master.xfer(1'b0, `REG_XER, 32'h0, q, e);
		check(q, {29'h0, xer});
		master.xfer(1'b0, `REG_CR0, 32'h0, q, e);
		check(q, {28'h0, cr0});
	endtask : run

	initial
	begin
		#20000;
		failures++;
		conclude();
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int r = 3; r < 8; r++)
		begin
			master.xfer(1'b0, 4'(r), 32'h0, q, e);
			check(q, 32'h0);
		end
		master.xfer(1'b0, 4'hF, 32'h0, q, e);
		check({31'h0, e}, 32'h1);
		for (int i = 0; i < 5; i++)
			for (int v = 0; v < 4; v++)
			begin
				run(0, va[i], vb[i], v[1], v[0]);
				run(1, va[i], vb[i], v[1], v[0]);
			end
		run(2, 32'h90003000, 32'h00007000, 1'b1, 1'b1);
		master.xfer(1'b0, `REG_RESULT, 32'h0, q, e);
		check(q, 32'h7000_4000);
		run(2, 32'h90003000, 32'h0000FFFF, 1'b0, 1'b0);
		master.xfer(1'b1, `REG_SRC_A, 32'h1111_1111, q, e);
		master.xfer(1'b1, `REG_SRC_A, 32'hAABB_CCDD, q, e, 4'h5);
		master.xfer(1'b0, `REG_SRC_A, 32'h0, q, e);
		check(q, 32'h11BB_11DD);
		master.xfer(1'b1, `REG_XER, 32'h0000_0005, q, e);
		xer = 3'h5;
		run(1, 32'h1, 32'h2, 1'b0, 1'b1);
		master.xfer(1'b0, `REG_RESULT, 32'h0, q, e);
		check(q, 32'h0000_0001);
		master.xfer(1'b1, `REG_RESULT, 32'hFFFFFFFF, q, e);
		master.xfer(1'b1, `REG_IRQ_MASK, 32'h4, q, e);
		run(3, 32'h1, 32'h2, 1'b1, 1'b1);
		@(negedge clk_i);
		check({31'h0, irq_o}, 32'h1);
		master.xfer(1'b0, `REG_IRQ_STAT, 32'h0, q, e);
		check(q, {29'h0, stat});
		stat = 3'h0;
		master.xfer(1'b0, `REG_IRQ_STAT, 32'h0, q, e);
		check(q, 32'h0);
		master.xfer(1'b1, `REG_IRQ_MASK, 32'h0, q, e);
		run(3, 32'h1, 32'h2, 1'b0, 1'b0);
		@(negedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		conclude();
	end
endmodule : subtract_carry_alu_test
